//--- design/uart_core.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module uart_core
  import uart_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_serial_in_pin,
  output logic             o_serial_out_pin,
  output logic             o_tx_done_irq,
  output logic             o_rx_done_irq,
  output logic             o_rx_err_irq
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        ack_q;
  logic        acc_wr;
  logic        acc_rd;
  logic [7:0]  serial_mode_reg_q;
  logic [7:0]  transfer_mode_reg_q;
  logic [15:0] baud_div_q;
  logic [7:0]  tx_buffer_q;
  logic [7:0]  rx_buffer_q;
  logic [2:0]  rx_error_status_q;
  logic        tx_buf_full_q;
  logic        tx_shift_full_q;
  logic [31:0] rd_d;

  // One wait state on every access; the access acts at the edge where wait is low
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign acc_wr = i_avs_write && ack_q;
  assign acc_rd = i_avs_read && ack_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (i_avs_address == OFS_SERIAL_MODE) begin
      rd_d[7:0] = serial_mode_reg_q;
    end else if (i_avs_address == OFS_TRANSFER_MODE) begin
      rd_d[7:0] = transfer_mode_reg_q;
    end else if (i_avs_address == OFS_BAUD_DIV) begin
      rd_d[15:0] = baud_div_q;
    end else if (i_avs_address == OFS_TX_BUFFER) begin
      rd_d[7:0] = tx_buffer_q;
    end else if (i_avs_address == OFS_RX_BUFFER) begin
      rd_d[7:0] = rx_buffer_q;
    end else if (i_avs_address == OFS_TX_STATUS) begin
      rd_d[TS_BUF_FULL] = tx_buf_full_q;
      rd_d[TS_SH_FULL]  = tx_shift_full_q;
    end else if (i_avs_address == OFS_RX_ERR_STATUS) begin
      rd_d[2:0] = rx_error_status_q;
    end
  end

  // Read data captured while waitrequest is high, stands at the accepting edge
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      o_avs_readdata <= rd_d;
    end
  end

  // Control registers
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      serial_mode_reg_q   <= SERIAL_MODE_RST;
      transfer_mode_reg_q <= TRANSFER_RST;
      baud_div_q          <= BAUD_DIV_RST;
    end else if (acc_wr) begin
      if (i_avs_address == OFS_SERIAL_MODE) begin
        serial_mode_reg_q <= i_avs_writedata[7:0];
      end else if (i_avs_address == OFS_TRANSFER_MODE) begin
        transfer_mode_reg_q <= i_avs_writedata[7:0];
      end else if (i_avs_address == OFS_BAUD_DIV) begin
        baud_div_q <= i_avs_writedata[15:0];
      end
    end
  end

  logic       uart_mode;
  logic       powered;
  logic       tx_on;
  logic       rx_on;
  logic [1:0] par_mode;
  logic       char8;
  logic       stop2;

  assign uart_mode = transfer_mode_reg_q[TM_MODE_HI:TM_MODE_LO] == MODE_UART;
  assign powered   = uart_mode && serial_mode_reg_q[SM_POWER];
  assign tx_on     = powered && serial_mode_reg_q[SM_TX_EN];
  assign rx_on     = powered && serial_mode_reg_q[SM_RX_EN];
  assign par_mode  = serial_mode_reg_q[SM_PAR_HI:SM_PAR_LO];
  assign char8     = serial_mode_reg_q[SM_CHAR8];
  assign stop2     = serial_mode_reg_q[SM_STOP2];

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  tx_state_t  tx_state_q;
  logic [7:0] tx_shift_reg_q;
  logic [2:0] tx_cnt_q;
  logic       tx_par_q;
  logic       tx_tick;
  logic       tx_wr_ok;
  logic       tx_frame_end;
  logic       tx_load;
  logic       tx_irq_evt;

  baud_gen u_tx_baud (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_clear   (tx_state_q == TX_IDLE || !tx_on),
    .i_div     (baud_div_q),
    .o_tick    (tx_tick),
    .o_half    ()
  );

  assign tx_wr_ok     = acc_wr && i_avs_address == OFS_TX_BUFFER && tx_on && !tx_buf_full_q;
  assign tx_frame_end = tx_tick && ((tx_state_q == TX_STOP1 && !stop2) || tx_state_q == TX_STOP2);
  assign tx_load      = tx_on && tx_buf_full_q && (tx_state_q == TX_IDLE || tx_frame_end);
  // Early interrupt after the first of two stop bits when selected
  assign tx_irq_evt   = (transfer_mode_reg_q[TM_INT_SEL] && stop2) ?
                        (tx_tick && tx_state_q == TX_STOP1) : tx_frame_end;

  // Buffer register and its full flag; a load and a write never meet
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_buffer_q   <= 8'h00;
      tx_buf_full_q <= 1'b0;
    end else if (!tx_on) begin
      tx_buf_full_q <= 1'b0;
    end else if (tx_wr_ok) begin
      tx_buffer_q   <= i_avs_writedata[7:0];
      tx_buf_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_q <= 1'b0;
    end
  end

  // Frame sequencer, serial output and shift-full flag
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state_q       <= TX_IDLE;
      tx_shift_reg_q   <= 8'h00;
      tx_cnt_q         <= 3'h0;
      tx_par_q         <= 1'b0;
      tx_shift_full_q  <= 1'b0;
      o_serial_out_pin <= 1'b1;
    end else if (!tx_on) begin
      tx_state_q       <= TX_IDLE;
      tx_shift_full_q  <= 1'b0;
      o_serial_out_pin <= 1'b1;
    end else if (tx_load) begin
      tx_state_q       <= TX_START;
      tx_shift_reg_q   <= tx_buffer_q;
      tx_par_q         <= par_mode == PAR_EVEN ? char_xor(tx_buffer_q, char8) :
                          par_mode == PAR_ODD ? !char_xor(tx_buffer_q, char8) : 1'b0;
      tx_cnt_q         <= 3'h0;
      tx_shift_full_q  <= 1'b1;
      o_serial_out_pin <= 1'b0;
    end else if (tx_frame_end) begin
      tx_state_q       <= TX_IDLE;
      tx_shift_full_q  <= 1'b0;
      o_serial_out_pin <= 1'b1;
    end else if (tx_tick) begin
      case (tx_state_q)
        TX_START: begin
          tx_state_q       <= TX_DATA;
          o_serial_out_pin <= tx_shift_reg_q[0];
          tx_shift_reg_q   <= {1'b0, tx_shift_reg_q[7:1]};
        end
        TX_DATA: begin
          if (tx_cnt_q == (char8 ? DATA_BITS_8 : DATA_BITS_7)) begin
            tx_state_q       <= par_mode == PAR_NONE ? TX_STOP1 : TX_PARITY;
            o_serial_out_pin <= par_mode == PAR_NONE ? 1'b1 : tx_par_q;
          end else begin
            tx_cnt_q         <= tx_cnt_q + 3'h1;
            o_serial_out_pin <= tx_shift_reg_q[0];
            tx_shift_reg_q   <= {1'b0, tx_shift_reg_q[7:1]};
          end
        end
        TX_PARITY: begin
          tx_state_q       <= TX_STOP1;
          o_serial_out_pin <= 1'b1;
        end
        TX_STOP1: begin
          tx_state_q <= TX_STOP2;
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Transmit completion pulse
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_done_irq <= 1'b0;
    end else begin
      o_tx_done_irq <= tx_on && tx_irq_evt;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  rx_state_t  rx_state_q;
  logic [7:0] rx_shift_reg_q;
  logic [2:0] rx_cnt_q;
  logic       rx_par_bit_q;
  logic       rx_prev_q;
  logic       rx_full_q;
  logic       rx_line;
  logic       rx_tick;
  logic       rx_half;
  logic       rx_done;
  logic [7:0] rx_char;
  logic       rx_perr;
  logic       rx_ferr;
  logic       rx_ovr;
  logic       rx_any_err;
  logic       rxb_read;

  bit_sync u_rx_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (i_serial_in_pin),
    .o_sync    (rx_line)
  );

  baud_gen u_rx_baud (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_clear   (rx_state_q == RX_IDLE || (rx_state_q == RX_START && rx_half)),
    .i_div     (baud_div_q),
    .o_tick    (rx_tick),
    .o_half    (rx_half)
  );

  // Only the first stop bit is examined
  assign rx_done    = rx_tick && rx_state_q == RX_STOP;
  assign rx_char    = char8 ? rx_shift_reg_q : {1'b0, rx_shift_reg_q[7:1]};
  assign rx_perr    = (par_mode == PAR_EVEN && (char_xor(rx_char, char8) ^ rx_par_bit_q)) ||
                      (par_mode == PAR_ODD && !(char_xor(rx_char, char8) ^ rx_par_bit_q));
  assign rx_ferr    = !rx_line;
  assign rx_ovr     = rx_full_q;
  assign rx_any_err = rx_perr || rx_ferr || rx_ovr;
  assign rxb_read   = acc_rd && i_avs_address == OFS_RX_BUFFER;

  // Start detection and bit sampling at mid-bit
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state_q     <= RX_IDLE;
      rx_shift_reg_q <= 8'h00;
      rx_cnt_q       <= 3'h0;
      rx_par_bit_q   <= 1'b0;
      rx_prev_q      <= 1'b1;
    end else if (!rx_on) begin
      rx_state_q <= RX_IDLE;
      rx_prev_q  <= 1'b1;
    end else begin
      rx_prev_q <= rx_line;
      case (rx_state_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_line) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_half) begin
            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_q   <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift_reg_q <= {rx_line, rx_shift_reg_q[7:1]};
            rx_cnt_q       <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == (char8 ? DATA_BITS_8 : DATA_BITS_7)) begin
              rx_state_q <= par_mode == PAR_NONE ? RX_STOP : RX_PARITY;
            end
          end
        end
        RX_PARITY: begin
          if (rx_tick) begin
            rx_par_bit_q <= rx_line;
            rx_state_q   <= RX_STOP;
          end
        end
        default: begin
          if (rx_tick) begin
            rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer, unread flag and error status; completion beats a read
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_buffer_q       <= 8'h00;
      rx_full_q         <= 1'b0;
      rx_error_status_q <= 3'h0;
    end else if (rx_done && rx_on) begin
      if (!rx_ovr) begin
        rx_buffer_q <= rx_char;
      end
      rx_full_q         <= 1'b1;
      rx_error_status_q <= {rx_perr, rx_ferr, rx_ovr};
    end else if (rxb_read) begin
      rx_full_q         <= 1'b0;
      rx_error_status_q <= 3'h0;
    end
  end

  // Completion and error pulses; errors fold into completion unless separated
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_done_irq <= 1'b0;
      o_rx_err_irq  <= 1'b0;
    end else begin
      o_rx_done_irq <= rx_on && rx_done && !(rx_any_err && serial_mode_reg_q[SM_ERR_SEP]);
      o_rx_err_irq  <= rx_on && rx_done && rx_any_err && serial_mode_reg_q[SM_ERR_SEP];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_tx_loaded;
    tx_state_q == TX_START && tx_shift_full_q && !o_serial_out_pin;
  endsequence

  property p_write_sets_full;
    @(posedge i_sys_clk) disable iff (!i_resetn) tx_wr_ok |=> tx_buf_full_q;
  endproperty
  a_write_sets_full: assert property (p_write_sets_full) else $error("tx write did not set full");

  property p_full_write_ignored;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      acc_wr && i_avs_address == OFS_TX_BUFFER && tx_buf_full_q |=> $stable(tx_buffer_q);
  endproperty
  a_full_write_ignored: assert property (p_full_write_ignored) else $error("full buffer overwritten");

  property p_start_loads;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      tx_on && tx_buf_full_q && tx_state_q == TX_IDLE && !tx_wr_ok |=> s_tx_loaded ##0 !tx_buf_full_q;
  endproperty
  a_start_loads: assert property (p_start_loads) else $error("start bit did not move byte");

  property p_off_idles_high;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      !tx_on |=> o_serial_out_pin && !tx_shift_full_q && !tx_buf_full_q;
  endproperty
  a_off_idles_high: assert property (p_off_idles_high) else $error("transmitter not initialised");

  property p_last_frame_flags;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      tx_on && tx_frame_end && !tx_buf_full_q && !tx_wr_ok |=> !tx_shift_full_q && !tx_buf_full_q;
  endproperty
  a_last_frame_flags: assert property (p_last_frame_flags) else $error("flags left set after frame");

  property p_overrun_keeps;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      rx_on && rx_done && rx_full_q |=> $stable(rx_buffer_q) && rx_error_status_q[ES_OVERRUN];
  endproperty
  a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun data not dropped");

  property p_rx_irq_with_buffer;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      $rose(o_rx_done_irq) && !rx_error_status_q[ES_OVERRUN] |-> rx_full_q && rx_buffer_q == $past(rx_char);
  endproperty
  a_rx_irq_with_buffer: assert property (p_rx_irq_with_buffer) else $error("buffer not copied");

  property p_read_clears_err;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      rxb_read && !(rx_done && rx_on) |=> rx_error_status_q == 3'h0 && !rx_full_q;
  endproperty
  a_read_clears_err: assert property (p_read_clears_err) else $error("error status not cleared");

  property p_bus_answers;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest;
  endproperty
  a_bus_answers: assert property (p_bus_answers) else $error("bus access not answered");

endmodule

//--- design/uart_pkg.sv
package uart_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_SERIAL_MODE   = 5'h00;
  localparam logic [4:0] OFS_TRANSFER_MODE = 5'h04;
  localparam logic [4:0] OFS_BAUD_DIV      = 5'h08;
  localparam logic [4:0] OFS_TX_BUFFER     = 5'h0C;
  localparam logic [4:0] OFS_RX_BUFFER     = 5'h10;
  localparam logic [4:0] OFS_TX_STATUS     = 5'h14;
  localparam logic [4:0] OFS_RX_ERR_STATUS = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SM_POWER    = 7;
  localparam int SM_TX_EN    = 6;
  localparam int SM_RX_EN    = 5;
  localparam int SM_PAR_HI   = 4;
  localparam int SM_PAR_LO   = 3;
  localparam int SM_CHAR8    = 2;
  localparam int SM_STOP2    = 1;
  localparam int SM_ERR_SEP  = 0;
  localparam int TM_MODE_HI  = 7;
  localparam int TM_MODE_LO  = 6;
  localparam int TM_INT_SEL  = 3;
  localparam int TS_BUF_FULL = 1;
  localparam int TS_SH_FULL  = 0;
  localparam int ES_PARITY   = 2;
  localparam int ES_FRAMING  = 1;
  localparam int ES_OVERRUN  = 0;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  PAR_NONE       = 2'h0;
  localparam logic [1:0]  PAR_ZERO       = 2'h1;
  localparam logic [1:0]  PAR_ODD        = 2'h2;
  localparam logic [1:0]  PAR_EVEN       = 2'h3;
  localparam logic [1:0]  MODE_UART      = 2'h0;
  localparam logic [7:0]  SERIAL_MODE_RST = 8'h04;
  localparam logic [7:0]  TRANSFER_RST    = 8'h00;
  localparam logic [15:0] BAUD_DIV_RST    = 16'h0010;
  localparam logic [2:0]  DATA_BITS_8    = 3'h7;
  localparam logic [2:0]  DATA_BITS_7    = 3'h6;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

  // Xor of the character bits that take part in a frame
  function automatic logic char_xor(input logic [7:0] data, input logic char8);
    char_xor = ^data[6:0] ^ (char8 & data[7]);
  endfunction

endpackage

//--- design/bit_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a pin that idles high
module bit_sync
  import uart_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

//--- design/baud_gen.sv
`timescale 1ns/1ps
// Bit-period counter with full and half period strobes
module baud_gen
  import uart_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clear,
  input  wire logic [15:0] i_div,
  output logic             o_tick,
  output logic             o_half
);

  logic [15:0] cnt_q;

  // Counter restarts on clear and wraps after one bit period
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 16'h0000;
    end else if (i_clear || o_tick) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Half strobe ignores the clear, since a caller may clear on the half strobe itself
  assign o_tick = !i_clear && (cnt_q == i_div - 16'h0001);
  assign o_half = (cnt_q == {1'b0, i_div[15:1]});

endmodule

//--- sim/uart_remote.sv
`timescale 1ns/1ps
// Far-end serial port: sends frames on request and captures frames sent to it
module uart_remote #(
  parameter int DIV = 8
) (
  input  wire logic i_sys_clk,
  input  wire logic i_line,
  output logic      o_line
);
  logic [7:0] rx_q [$];
  logic [7:0] sh;

  // Line idles high between frames
  initial o_line = 1'b1;

  // Frame out: start, 8 data bits LSB first, optional parity, one stop
  // A low stop bit makes a framing fault; the line then returns high
  task automatic send(input logic [7:0] d, input logic par_on, input logic par, input logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || par_on) begin
        o_line <= f[i];
        repeat (DIV) @(posedge i_sys_clk);
      end
    end
    if (!stp) o_line <= 1'b1;
  endtask

  // Frame in: find start edge, sample each bit at its centre
  always begin
    @(negedge i_line);
    repeat (DIV / 2) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge i_sys_clk);
      sh[i] = i_line;
    end
    repeat (DIV) @(posedge i_sys_clk);
    rx_q.push_back(sh);
  end
endmodule

//--- sim/uart_successive_tx_and_rx_bench.sv
`timescale 1ns/1ps
// Bench for the serial engine: register bus, back-to-back send, receive errors
module uart_successive_tx_and_rx_bench
  import uart_pkg::*;
;
  localparam int DIV = 8;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_rq;
  logic        line_in;
  logic        line_out;
  logic        tx_irq;
  logic        rx_irq;
  logic        er_irq;
  logic [7:0]  v;
  int          err_count = 0;
  int          compares = 0;

  uart_core uart_core_i (.i_sys_clk(clk), .i_resetn(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
    .i_serial_in_pin(line_in), .o_serial_out_pin(line_out), .o_tx_done_irq(tx_irq),
    .o_rx_done_irq(rx_irq), .o_rx_err_irq(er_irq));
  uart_remote #(.DIV(DIV)) uart_remote_i (.i_sys_clk(clk), .i_line(line_out), .o_line(line_in));

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  // Clock and watchdog
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= {24'h000000, d};
    do @(posedge clk); while (wait_rq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    do @(posedge clk); while (wait_rq !== 1'b0);
    d = rdata[7:0];
    rd <= 1'b0;
  endtask
  task automatic wait_irq(input int which);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (n < 3000 && ((which == 0) ? tx_irq : (which == 1) ? rx_irq : er_irq) !== 1'b1);
    chk({7'h00, n < 3000}, 8'h01);
  endtask
  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Two queued bytes leave back to back; a third write to a full buffer is dropped
  task automatic t_burst();
    bus_wr(OFS_TX_BUFFER, 8'hA5);
    bus_wr(OFS_TX_BUFFER, 8'h3C);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h03);
    bus_wr(OFS_TX_BUFFER, 8'hFF);
    wait_irq(0);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h01);
    wait_irq(0);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h00);
    repeat (2 * DIV) @(posedge clk);
    chk(8'(uart_remote_i.rx_q.size()), 8'h02);
    chk(uart_remote_i.rx_q[0], 8'hA5);
    chk(uart_remote_i.rx_q[1], 8'h3C);
  endtask
  // Early interrupt with two stops; transmitter shut down only after the last frame
  task automatic t_init();
    bus_wr(OFS_TRANSFER_MODE, 8'h08);
    bus_wr(OFS_SERIAL_MODE, 8'hE6);
    bus_wr(OFS_TX_BUFFER, 8'h5A);
    wait_irq(0);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h01);
    repeat (2 * DIV) @(posedge clk);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h00);
    bus_wr(OFS_SERIAL_MODE, 8'hA6);
    bus_wr(OFS_TX_BUFFER, 8'hC3);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h00);
    chk({7'h00, line_out}, 8'h01);
    bus_wr(OFS_TRANSFER_MODE, 8'h00);
    bus_wr(OFS_SERIAL_MODE, 8'hE4);
    repeat (2 * DIV) @(posedge clk);
    chk(8'(uart_remote_i.rx_q.size()), 8'h03);
    chk(uart_remote_i.rx_q[2], 8'h5A);
  endtask
  // Good byte, overrun, parity and framing errors, and only one stop bit checked
  task automatic t_rx();
    uart_remote_i.send(8'h96, 1'b0, 1'b0, 1'b1);
    wait_irq(1);
    bus_rd(OFS_RX_BUFFER, v);
    chk(v, 8'h96);
    uart_remote_i.send(8'h11, 1'b0, 1'b0, 1'b1);
    wait_irq(1);
    uart_remote_i.send(8'h22, 1'b0, 1'b0, 1'b1);
    wait_irq(1);
    bus_rd(OFS_RX_ERR_STATUS, v);
    chk(v, 8'h01);
    bus_rd(OFS_RX_BUFFER, v);
    chk(v, 8'h11);
    bus_rd(OFS_RX_ERR_STATUS, v);
    chk(v, 8'h00);
    bus_wr(OFS_SERIAL_MODE, 8'hFD);
    uart_remote_i.send(8'h07, 1'b1, 1'b0, 1'b1);
    wait_irq(2);
    bus_rd(OFS_RX_ERR_STATUS, v);
    chk(v, 8'h04);
    bus_rd(OFS_RX_BUFFER, v);
    chk(v, 8'h07);
    uart_remote_i.send(8'h03, 1'b1, 1'b0, 1'b0);
    wait_irq(2);
    bus_rd(OFS_RX_ERR_STATUS, v);
    chk(v, 8'h02);
    bus_rd(OFS_RX_BUFFER, v);
    chk(v, 8'h03);
    bus_wr(OFS_SERIAL_MODE, 8'hE6);
    uart_remote_i.send(8'h5C, 1'b0, 1'b0, 1'b1);
    uart_remote_i.send(8'hA3, 1'b0, 1'b0, 1'b1);
    wait_irq(1);
    bus_rd(OFS_RX_ERR_STATUS, v);
    chk(v, 8'h01);
    bus_rd(OFS_RX_BUFFER, v);
    chk(v, 8'h5C);
  endtask

  // Main sequence: reset, check defaults, configure, run scenarios
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({7'h00, line_out}, 8'h01);
    bus_rd(OFS_SERIAL_MODE, v);
    chk(v, SERIAL_MODE_RST);
    bus_rd(OFS_TX_STATUS, v);
    chk(v, 8'h00);
    bus_wr(OFS_BAUD_DIV, 8'(DIV));
    bus_wr(OFS_SERIAL_MODE, 8'hE4);
    t_burst();
    t_init();
    t_rx();
    end_of_test();
  end
endmodule
